// ### common/smbsd_pkg.sv
// Shared constants and types for the slave status decoder
package smbsd_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned VEC_W  = 4;
  localparam int unsigned BYTE_W = 8;

  // ----------------------------------------
  // Status vector: master, tx direction, start, stop
  // ----------------------------------------
  localparam int unsigned VEC_MASTER_BIT = 3;
  localparam int unsigned VEC_TXDIR_BIT  = 2;
  localparam int unsigned VEC_START_BIT  = 1;
  localparam int unsigned VEC_STOP_BIT   = 0;

  localparam logic [VEC_W-1:0] ST_SLV_RX   = 4'h0;
  localparam logic [VEC_W-1:0] ST_STOP     = 4'h1;
  localparam logic [VEC_W-1:0] ST_ADDR     = 4'h2;
  localparam logic [VEC_W-1:0] ST_SLV_TX   = 4'h4;
  localparam logic [VEC_W-1:0] ST_TX_ERR   = 4'h5;
  localparam logic [VEC_W-1:0] ST_MSTART   = 4'hE;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [VEC_W-1:0]  RST_VEC  = 4'h0;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;

  // ----------------------------------------
  // Synchroniser depth in cycles
  // ----------------------------------------
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------
  // Bus events reported by the link side
  // ----------------------------------------
  typedef enum logic [3:0] {
    EVT_START,
    EVT_ADDR,
    EVT_RX_BYTE,
    EVT_TX_DONE,
    EVT_STOP,
    EVT_BUS_ERR,
    EVT_ARB_RSTART,
    EVT_ARB_STOP,
    EVT_ARB_DATA,
    EVT_ARB_STOP_TRY,
    EVT_MSTART
  } smbsd_evt_t;

endpackage

// ### common/smbsd_link_if.sv
// Carrier between the core domain and the link domain
`timescale 1ns/1ps
interface smbsd_link_if;
  import smbsd_pkg::*;

  // ----------------------------------------
  // Link to core: event held until release
  // ----------------------------------------
  logic               evt_tgl;
  smbsd_evt_t         evt_code;
  logic               evt_arb;
  logic               evt_ack;
  logic [BYTE_W-1:0]  evt_byte;

  // ----------------------------------------
  // Core to link: response held until next event
  // ----------------------------------------
  logic               rel_tgl;
  logic               rsp_ack;
  logic               rsp_sta;
  logic               rsp_sto;
  logic               rsp_tx_valid;
  logic [BYTE_W-1:0]  rsp_byte;

  modport link (output evt_tgl, evt_code, evt_arb, evt_ack, evt_byte,
                input  rel_tgl, rsp_ack, rsp_sta, rsp_sto, rsp_tx_valid, rsp_byte);
  modport core (input  evt_tgl, evt_code, evt_arb, evt_ack, evt_byte,
                output rel_tgl, rsp_ack, rsp_sta, rsp_sto, rsp_tx_valid, rsp_byte);
endinterface

// ### hw/smbsd_tgl_sync.sv
// Toggle synchroniser turning a far-domain toggle into a local pulse
`timescale 1ns/1ps
module smbsd_tgl_sync (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_tgl,
  output logic      o_pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ----------------------------------------
  // Two stages, then an edge detector on the second
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_tgl;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign o_pulse = s2_q ^ s3_q;
endmodule

// ### hw/smbsd_link_side.sv
// Link-clock logic: catches bus events and stretches until released
`timescale 1ns/1ps
module smbsd_link_side (
  input  wire logic               i_link_clk,
  input  wire logic               i_rst,
  input  wire logic               i_evt_valid,
  input  smbsd_pkg::smbsd_evt_t   i_evt_code,
  input  wire logic               i_evt_arb,
  input  wire logic               i_evt_ack,
  input  wire logic [7:0]         i_evt_byte,
  output logic                    o_stretch,
  output logic                    o_ack,
  output logic                    o_start_req,
  output logic                    o_stop_req,
  output logic                    o_tx_valid,
  output logic [7:0]              o_tx_byte,
  smbsd_link_if.link              lk
);
  import smbsd_pkg::*;

  logic rel_pulse;

  smbsd_tgl_sync u_rel_sync (
    .i_clk   (i_link_clk),
    .i_rst   (i_rst),
    .i_tgl   (lk.rel_tgl),
    .o_pulse (rel_pulse)
  );

  // ----------------------------------------
  // Event capture; fields stay put while stretched
  // ----------------------------------------
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      lk.evt_tgl  <= 1'b0;
      lk.evt_code <= EVT_START;
      lk.evt_arb  <= 1'b0;
      lk.evt_ack  <= 1'b0;
      lk.evt_byte <= RST_BYTE;
    end else if (i_evt_valid && !o_stretch) begin
      lk.evt_tgl  <= ~lk.evt_tgl;
      lk.evt_code <= i_evt_code;
      lk.evt_arb  <= i_evt_arb;
      lk.evt_ack  <= i_evt_ack;
      lk.evt_byte <= i_evt_byte;
    end
  end

  // ----------------------------------------
  // Stretch and response outputs
  // ----------------------------------------
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      o_stretch   <= 1'b0;
      o_ack       <= 1'b0;
      o_start_req <= 1'b0;
      o_stop_req  <= 1'b0;
      o_tx_valid  <= 1'b0;
      o_tx_byte   <= RST_BYTE;
    end else if (rel_pulse) begin
      o_stretch   <= 1'b0;
      o_ack       <= lk.rsp_ack;
      o_start_req <= lk.rsp_sta;
      o_stop_req  <= lk.rsp_sto;
      o_tx_valid  <= lk.rsp_tx_valid;
      o_tx_byte   <= lk.rsp_byte;
    end else if (i_evt_valid && !o_stretch) begin
      o_stretch   <= 1'b1;
    end
  end
endmodule

// ### hw/smbsd_core.sv
// Slave status decoder: status vector, flags and software response
//
// Function
// - Status vector is master, transmit direction, start flag, stop flag.
// - 0100 with NACK: no action; STOP then reports 0001.
// - 0100 with ACK: software loads next byte; stays in 0100.
// - 0100 with arbitration lost: error; master ends, then 0001.
// - 0101 on illegal STOP or bus error in slave transmit.
// - 0010 address received: ACK write, load and ACK read, or NACK.
// - 0010 lost arbitration then addressed: also start plus NACK reschedules.
// - 0001 STOP while addressed; software clears the stop flag.
// - 0001 with both flags: lost arbitration attempting STOP, no action.
// - 0000 byte received: ACK and read, or NACK ends it.
// - 0010 lost arbitration on repeated START; abort or retry.
// - 0001 lost arbitration on detected STOP; abort or retry.
// - 0000 lost arbitration sending master data; ACK 0, abort or retry.
`timescale 1ns/1ps
module smbsd_core (
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_sys_rst,
  input  wire logic                         i_link_clk,
  // Link-domain event port
  input  wire logic                         i_lk_evt_valid,
  input  smbsd_pkg::smbsd_evt_t             i_lk_evt_code,
  input  wire logic                         i_lk_evt_arb,
  input  wire logic                         i_lk_evt_ack,
  input  wire logic [smbsd_pkg::BYTE_W-1:0] i_lk_evt_byte,
  output logic                              o_lk_stretch,
  output logic                              o_lk_ack,
  output logic                              o_lk_start_req,
  output logic                              o_lk_stop_req,
  output logic                              o_lk_tx_valid,
  output logic [smbsd_pkg::BYTE_W-1:0]      o_lk_tx_byte,
  // Software side
  input  wire logic                         i_sw_sta,
  input  wire logic                         i_sw_sto,
  input  wire logic                         i_sw_ack,
  input  wire logic                         i_sw_event_clr,
  input  wire logic                         i_sw_data_wr,
  input  wire logic [smbsd_pkg::BYTE_W-1:0] i_sw_data,
  input  wire logic                         i_sw_err_clr,
  output logic [smbsd_pkg::VEC_W-1:0]       o_status_vec,
  output logic                              o_ack_request_flag,
  output logic                              o_arbitration_lost_flag,
  output logic                              o_ack_flag,
  output logic                              o_event_flag,
  output logic [smbsd_pkg::BYTE_W-1:0]      o_bus_data_reg,
  output logic                              o_tx_error,
  output logic                              o_slave_inhibit
);
  import smbsd_pkg::*;

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  // Decode tables assume these widths
  if (VEC_W != 4 || BYTE_W != 8) begin : g_width_chk
    $error("unsupported vector or byte width");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smbsd_link_if lk ();

  logic              evt_pulse;
  logic              evt_take;
  logic              evt_auto;
  logic              sw_commit;
  logic              rel_tgl_q;
  logic              rsp_ack_q;
  logic              rsp_sta_q;
  logic              rsp_sto_q;
  logic              rsp_tx_valid_q;
  logic [BYTE_W-1:0] tx_byte_q;
  logic              tx_loaded_q;
  logic              addr_read_q;
  logic [VEC_W-1:0]  evt_vec;
  logic              evt_ack_request_flag;
  logic              evt_arb;

  // ----------------------------------------
  // Event to status vector and ack-request
  // ----------------------------------------
  function automatic logic [VEC_W:0] evt_decode(input smbsd_evt_t code);
    logic [VEC_W:0] r;
    r = {RST_VEC, 1'b0};
    case (code)
      EVT_ADDR: begin
        r = {ST_ADDR, 1'b1};
      end
      EVT_RX_BYTE: begin
        r = {ST_SLV_RX, 1'b1};
      end
      EVT_TX_DONE: begin
        r = {ST_SLV_TX, 1'b0};
      end
      EVT_STOP: begin
        r = {ST_STOP, 1'b0};
      end
      EVT_BUS_ERR: begin
        r = {ST_TX_ERR, 1'b0};
      end
      EVT_ARB_RSTART: begin
        r = {ST_ADDR, 1'b0};
      end
      EVT_ARB_STOP: begin
        r = {ST_STOP, 1'b0};
      end
      EVT_ARB_DATA: begin
        r = {ST_SLV_RX, 1'b1};
      end
      EVT_ARB_STOP_TRY: begin
        r = {ST_STOP, 1'b1};
      end
      EVT_MSTART: begin
        r = {ST_MSTART, 1'b0};
      end
      default: begin
        r = {RST_VEC, 1'b0};
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Which events carry arbitration-lost
  // ----------------------------------------
  function automatic logic evt_arb_of(input smbsd_evt_t code, input logic arb);
    logic r;
    r = 1'b0;
    case (code)
      EVT_ADDR, EVT_TX_DONE: begin
        r = arb;
      end
      EVT_ARB_RSTART, EVT_ARB_STOP, EVT_ARB_DATA, EVT_ARB_STOP_TRY: begin
        r = 1'b1;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Link domain and crossing
  // ----------------------------------------
  smbsd_link_side u_link (
    .i_link_clk  (i_link_clk),
    .i_rst       (i_sys_rst),
    .i_evt_valid (i_lk_evt_valid),
    .i_evt_code  (i_lk_evt_code),
    .i_evt_arb   (i_lk_evt_arb),
    .i_evt_ack   (i_lk_evt_ack),
    .i_evt_byte  (i_lk_evt_byte),
    .o_stretch   (o_lk_stretch),
    .o_ack       (o_lk_ack),
    .o_start_req (o_lk_start_req),
    .o_stop_req  (o_lk_stop_req),
    .o_tx_valid  (o_lk_tx_valid),
    .o_tx_byte   (o_lk_tx_byte),
    .lk          (lk.link)
  );

  // Event fields are held in the link domain until release, so they
  // are stable long before the synchronised toggle edge arrives.
  smbsd_tgl_sync u_evt_sync (
    .i_clk   (i_sys_clk),
    .i_rst   (i_sys_rst),
    .i_tgl   (lk.evt_tgl),
    .o_pulse (evt_pulse)
  );

  assign lk.rel_tgl      = rel_tgl_q;
  assign lk.rsp_ack      = rsp_ack_q;
  assign lk.rsp_sta      = rsp_sta_q;
  assign lk.rsp_sto      = rsp_sto_q;
  assign lk.rsp_tx_valid = rsp_tx_valid_q;
  assign lk.rsp_byte     = tx_byte_q;

  // ----------------------------------------
  // Event classification
  // ----------------------------------------
  // START and inhibited slave traffic are answered without software.
  always_comb begin
    evt_auto = 1'b0;
    if (lk.evt_code == EVT_START) begin
      evt_auto = 1'b1;
    end else if (o_slave_inhibit &&
                 (lk.evt_code == EVT_ADDR || lk.evt_code == EVT_RX_BYTE)) begin
      evt_auto = 1'b1;
    end
  end

  assign evt_take  = evt_pulse && !evt_auto;
  assign sw_commit = i_sw_event_clr && o_event_flag && !evt_take;
  assign {evt_vec, evt_ack_request_flag} = evt_decode(lk.evt_code);
  assign evt_arb   = evt_arb_of(lk.evt_code, lk.evt_arb);

  // ----------------------------------------
  // Serial event flag
  // ----------------------------------------
  // A new event wins over a clear in the same cycle.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_event_flag <= 1'b0;
    end else if (evt_take) begin
      o_event_flag <= 1'b1;
    end else if (sw_commit) begin
      o_event_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // Status vector and flags
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_status_vec            <= RST_VEC;
      o_ack_request_flag      <= 1'b0;
      o_arbitration_lost_flag <= 1'b0;
    end else if (evt_take) begin
      o_status_vec            <= evt_vec;
      o_ack_request_flag      <= evt_ack_request_flag;
      o_arbitration_lost_flag <= evt_arb;
    end else if (sw_commit) begin
      // Software's start and stop values land in the vector
      o_status_vec[VEC_START_BIT] <= i_sw_sta;
      o_status_vec[VEC_STOP_BIT]  <= i_sw_sto;
      o_ack_request_flag          <= 1'b0;
    end
  end

  // ----------------------------------------
  // ACK flag: master's bit on transmit, software's on commit
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ack_flag <= 1'b0;
    end else if (evt_take && lk.evt_code == EVT_TX_DONE) begin
      o_ack_flag <= lk.evt_ack;
    end else if (sw_commit) begin
      o_ack_flag <= i_sw_ack;
    end
  end

  // ----------------------------------------
  // Data register: received byte in, transmit byte out
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus_data_reg <= RST_BYTE;
    end else if (evt_take &&
                 (lk.evt_code == EVT_ADDR || lk.evt_code == EVT_RX_BYTE)) begin
      o_bus_data_reg <= lk.evt_byte;
    end else if (i_sw_data_wr) begin
      o_bus_data_reg <= i_sw_data;
    end
  end

  // Direction bit of the address, kept for the commit decision
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_read_q <= 1'b0;
    end else if (evt_take && lk.evt_code == EVT_ADDR) begin
      addr_read_q <= lk.evt_byte[0];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_byte_q   <= RST_BYTE;
      tx_loaded_q <= 1'b0;
    end else if (i_sw_data_wr) begin
      tx_byte_q   <= i_sw_data;
      tx_loaded_q <= 1'b1;
    end else if (sw_commit) begin
      tx_loaded_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write after a NACK in slave transmit is an error
  // ----------------------------------------
  // Sticky; a new error wins over the clear.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_error <= 1'b0;
    end else if (i_sw_data_wr && o_event_flag && !o_ack_flag &&
                 o_status_vec == ST_SLV_TX && !o_arbitration_lost_flag) begin
      o_tx_error <= 1'b1;
    end else if (i_sw_err_clr) begin
      o_tx_error <= 1'b0;
    end
  end

  // ----------------------------------------
  // Slave inhibit after an ignored address
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_slave_inhibit <= 1'b0;
    end else if (evt_pulse && lk.evt_code == EVT_START) begin
      o_slave_inhibit <= 1'b0;
    end else if (sw_commit && o_status_vec == ST_ADDR &&
                 o_ack_request_flag && !i_sw_ack && !i_sw_sta) begin
      o_slave_inhibit <= 1'b1;
    end
  end

  // ----------------------------------------
  // Response to the link and release
  // ----------------------------------------
  // Response flags change only here and are held until the next
  // event, so the link side may take them on its release pulse.
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rel_tgl_q      <= 1'b0;
      rsp_ack_q      <= 1'b0;
      rsp_sta_q      <= 1'b0;
      rsp_sto_q      <= 1'b0;
      rsp_tx_valid_q <= 1'b0;
    end else if (evt_pulse && evt_auto) begin
      rel_tgl_q      <= ~rel_tgl_q;
      rsp_ack_q      <= 1'b0;
      rsp_sta_q      <= 1'b0;
      rsp_sto_q      <= 1'b0;
      rsp_tx_valid_q <= 1'b0;
    end else if (sw_commit) begin
      rel_tgl_q      <= ~rel_tgl_q;
      rsp_ack_q      <= i_sw_ack;
      rsp_sta_q      <= i_sw_sta;
      rsp_sto_q      <= i_sw_sto;
      // Only a loaded byte is sent; otherwise the link falls back to
      // receiving, which is how an unloaded transmit turn ends.
      rsp_tx_valid_q <= tx_loaded_q && !o_arbitration_lost_flag &&
                        ((o_status_vec == ST_ADDR && addr_read_q && i_sw_ack) ||
                         (o_status_vec == ST_SLV_TX && o_ack_flag));
    end
  end
endmodule

// ### tb/smbsd_core_checker.sv
// Port assertions for the slave status decoder
`timescale 1ns/1ps
module smbsd_core_checker (
  input wire logic                        i_sys_clk,
  input wire logic                        i_sys_rst,
  input wire logic                        i_link_clk,
  input wire logic                        i_lk_evt_valid,
  input wire logic                        i_sw_sta,
  input wire logic                        i_sw_sto,
  input wire logic                        i_sw_event_clr,
  input wire logic                        o_lk_stretch,
  input wire logic [smbsd_pkg::VEC_W-1:0] o_status_vec,
  input wire logic                        o_ack_request_flag,
  input wire logic                        o_arbitration_lost_flag,
  input wire logic                        o_event_flag
);
  import smbsd_pkg::*;
  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  a_evt_stretch: assert property (
    @(posedge i_link_clk) disable iff (i_sys_rst)
    i_lk_evt_valid && !o_lk_stretch |=> o_lk_stretch) else $error("no stretch after event");
  // ----------------------------------------
  // Core domain
  // ----------------------------------------
  a_flag_stretch: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag |-> o_lk_stretch) else $error("released while pending");
  a_status_hold: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && !i_sw_event_clr |=> o_event_flag && $stable(o_status_vec)
      && $stable(o_ack_request_flag) && $stable(o_arbitration_lost_flag))
    else $error("status moved before clear");
  a_commit_clear: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && i_sw_event_clr |=> !o_event_flag && !o_ack_request_flag)
    else $error("clear did not drop flags");
  a_commit_bits: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && i_sw_event_clr |=> o_status_vec[VEC_START_BIT] == $past(i_sw_sta)
      && o_status_vec[VEC_STOP_BIT] == $past(i_sw_sto)) else $error("start/stop not taken");
  a_tx_noreq: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && o_status_vec == ST_SLV_TX |-> !o_ack_request_flag)
    else $error("ack request in slave transmit");
  a_err_noreq: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && o_status_vec == ST_TX_ERR |-> !o_ack_request_flag)
    else $error("ack request on bus error");
  a_rx_ackreq: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && o_status_vec == ST_SLV_RX |-> o_ack_request_flag)
    else $error("byte without ack request");
  a_rstart_arb: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && o_status_vec == ST_ADDR && !o_ack_request_flag |-> o_arbitration_lost_flag)
    else $error("0010 lacks arb lost");
  a_stoptry_arb: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && o_status_vec == ST_STOP && o_ack_request_flag |-> o_arbitration_lost_flag)
    else $error("0001 lacks arb lost");
  a_master_start: assert property (
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    o_event_flag && o_status_vec[VEC_MASTER_BIT] |-> o_status_vec == ST_MSTART)
    else $error("master bit outside 1110");
endmodule
bind smbsd_core smbsd_core_checker i_smbsd_core_checker (.*);

// ### tb/smbsd_bus_master.sv
// Far-side model: external bus master reporting bus events
`timescale 1ns/1ps
module smbsd_bus_master (
  input  wire logic                        i_link_clk,
  input  wire logic                        i_stretch,
  output logic                             o_valid,
  output smbsd_pkg::smbsd_evt_t            o_code,
  output logic                             o_arb,
  output logic                             o_ack,
  output logic [smbsd_pkg::BYTE_W-1:0]     o_byte
);
  import smbsd_pkg::*;
  initial begin
    o_valid = 1'b0;
    o_code  = EVT_STOP;
    o_arb   = 1'b0;
    o_ack   = 1'b0;
    o_byte  = 8'h00;
  end
  // ----------------------------------------
  // One bus event, once the bus is free or after 400 link cycles of waiting
  // ----------------------------------------
  task automatic send(input smbsd_evt_t c, input logic a, k, input logic [BYTE_W-1:0] b);
    int n;
    n = 0;
    @(negedge i_link_clk);
    while (i_stretch !== 1'b0 && n < 400) begin
      @(negedge i_link_clk);
      n++;
    end
    o_valid = 1'b1;
    o_code  = c;
    o_arb   = a;
    o_ack   = k;
    o_byte  = b;
    @(negedge i_link_clk);
    o_valid = 1'b0;
    // Idle lines show the inverse
    o_arb   = ~a;
    o_ack   = ~k;
    o_byte  = ~b;
  endtask
endmodule

// ### tb/smbsd_test.sv
// Self-checking bench for the slave status decoder
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); \
    end \
  end
module smbsd_test;
  import smbsd_pkg::*;
  logic              i_sys_clk, i_sys_rst, i_link_clk, i_lk_evt_valid, i_lk_evt_arb;
  logic              i_lk_evt_ack, i_sw_sta, i_sw_sto, i_sw_ack, i_sw_event_clr;
  logic              i_sw_data_wr, i_sw_err_clr, o_lk_stretch, o_lk_ack, o_lk_start_req;
  logic              o_lk_stop_req, o_lk_tx_valid, o_ack_request_flag, o_ack_flag;
  logic              o_arbitration_lost_flag, o_event_flag, o_tx_error, o_slave_inhibit;
  logic [BYTE_W-1:0] i_lk_evt_byte, i_sw_data, o_lk_tx_byte, o_bus_data_reg;
  logic [VEC_W-1:0]  o_status_vec;
  smbsd_evt_t        i_lk_evt_code;
  int                err_count = 0;
  int                check_count = 0;
  smbsd_evt_t        codes[5] = '{EVT_ARB_RSTART, EVT_ARB_STOP, EVT_ARB_DATA,
                                  EVT_ARB_STOP_TRY, EVT_MSTART};
  logic [5:0]        exps[5] = '{6'h09, 6'h05, 6'h03, 6'h07, 6'h38};
  logic              stas[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  smbsd_core i_smbsd_core (.*);
  smbsd_bus_master i_smbsd_bus_master (.i_link_clk, .i_stretch(o_lk_stretch),
    .o_valid(i_lk_evt_valid), .o_code(i_lk_evt_code), .o_arb(i_lk_evt_arb),
    .o_ack(i_lk_evt_ack), .o_byte(i_lk_evt_byte));

  // ----------------------------------------
  // Clocks and access tasks
  // ----------------------------------------
  always #4 i_sys_clk = ~i_sys_clk;
  initial begin
    i_link_clk = 1'b0;
    #5.3;
    forever #32 i_link_clk = ~i_link_clk;
  end
  task automatic wait_flag();
    for (int n = 0; n < 200 && o_event_flag !== 1'b1; n++) @(negedge i_sys_clk);
    `CHK(o_event_flag, 1'b1)
  endtask
  task automatic wait_free();
    for (int n = 0; n < 300 && o_lk_stretch !== 1'b0; n++) @(negedge i_sys_clk);
    `CHK(o_lk_stretch, 1'b0)
  endtask
  task automatic ev(input smbsd_evt_t c, input logic a, k, input logic [BYTE_W-1:0] b);
    i_smbsd_bus_master.send(c, a, k, b);
    wait_flag();
  endtask
  task automatic aut(input smbsd_evt_t c);
    i_smbsd_bus_master.send(c, 1'b0, 1'b0, 8'hA5);
    wait_free();
  endtask
  task automatic st(input logic [3:0] v, input logic r, a);
    `CHK({o_status_vec, o_ack_request_flag, o_arbitration_lost_flag}, {v, r, a})
  endtask
  task automatic lk(input logic [3:0] e);
    `CHK({o_lk_ack, o_lk_start_req, o_lk_stop_req, o_lk_tx_valid}, e)
  endtask
  task automatic wr(input logic [BYTE_W-1:0] b);
    @(negedge i_sys_clk);
    i_sw_data_wr = 1'b1;
    i_sw_data = b;
    @(negedge i_sys_clk);
    i_sw_data_wr = 1'b0;
  endtask
  task automatic commit(input logic s, p, k);
    @(negedge i_sys_clk);
    i_sw_sta = s;
    i_sw_sto = p;
    i_sw_ack = k;
    i_sw_event_clr = 1'b1;
    @(negedge i_sys_clk);
    i_sw_event_clr = 1'b0;
    wait_free();
    @(negedge i_sys_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {i_sys_clk, i_sw_sta, i_sw_sto, i_sw_ack, i_sw_event_clr, i_sw_data_wr, i_sw_err_clr} = '0;
    i_sw_data = 8'h00;
    i_sys_rst = 1'b1;
    // Covers two link edges too
    repeat (2) @(posedge i_link_clk);
    @(negedge i_sys_clk);
    i_sys_rst = 1'b0;
    repeat (3) @(posedge i_link_clk);
    `CHK({o_status_vec, o_event_flag, o_lk_stretch, o_lk_tx_valid}, 7'h00)
    aut(EVT_START);
    ev(EVT_ADDR, 1'b0, 1'b0, 8'hA1);
    st(ST_ADDR, 1'b1, 1'b0);
    wr(8'h5C);
    commit(1'b0, 1'b0, 1'b1);
    lk(4'h9);
    `CHK(o_lk_tx_byte, 8'h5C)
    ev(EVT_TX_DONE, 1'b0, 1'b1, 8'h00);
    st(ST_SLV_TX, 1'b0, 1'b0);
    `CHK(o_ack_flag, 1'b1)
    wr(8'h3D);
    commit(1'b0, 1'b0, 1'b1);
    lk(4'h9);
    `CHK(o_lk_tx_byte, 8'h3D)
    ev(EVT_TX_DONE, 1'b0, 1'b0, 8'h00);
    st(ST_SLV_TX, 1'b0, 1'b0);
    wr(8'hEE);
    @(negedge i_sys_clk);
    `CHK(o_tx_error, 1'b1)
    i_sw_err_clr = 1'b1;
    @(negedge i_sys_clk);
    i_sw_err_clr = 1'b0;
    @(negedge i_sys_clk);
    `CHK(o_tx_error, 1'b0)
    commit(1'b0, 1'b0, 1'b0);
    lk(4'h0);
    ev(EVT_STOP, 1'b0, 1'b0, 8'h00);
    st(ST_STOP, 1'b0, 1'b0);
    commit(1'b0, 1'b0, 1'b0);
    `CHK(o_status_vec, 4'h0)
    $display("slave read test done");
    aut(EVT_START);
    ev(EVT_ADDR, 1'b0, 1'b0, 8'hA1);
    wr(8'h11);
    commit(1'b0, 1'b0, 1'b1);
    ev(EVT_TX_DONE, 1'b1, 1'b1, 8'h00);
    st(ST_SLV_TX, 1'b0, 1'b1);
    commit(1'b0, 1'b0, 1'b0);
    lk(4'h0);
    ev(EVT_STOP, 1'b0, 1'b0, 8'h00);
    st(ST_STOP, 1'b0, 1'b0);
    commit(1'b0, 1'b0, 1'b0);
    ev(EVT_BUS_ERR, 1'b0, 1'b0, 8'h00);
    st(ST_TX_ERR, 1'b0, 1'b0);
    commit(1'b0, 1'b0, 1'b0);
    `CHK(o_status_vec, 4'h4)
    $display("transmit error test done");
    aut(EVT_START);
    ev(EVT_ADDR, 1'b0, 1'b0, 8'hA0);
    commit(1'b0, 1'b0, 1'b1);
    lk(4'h8);
    ev(EVT_RX_BYTE, 1'b0, 1'b0, 8'h77);
    st(ST_SLV_RX, 1'b1, 1'b0);
    `CHK(o_bus_data_reg, 8'h77)
    commit(1'b0, 1'b0, 1'b0);
    lk(4'h0);
    ev(EVT_ADDR, 1'b1, 1'b0, 8'hA1);
    st(ST_ADDR, 1'b1, 1'b1);
    commit(1'b1, 1'b0, 1'b0);
    lk(4'h4);
    `CHK(o_slave_inhibit, 1'b0)
    ev(EVT_ADDR, 1'b0, 1'b0, 8'hA0);
    commit(1'b0, 1'b0, 1'b0);
    `CHK(o_slave_inhibit, 1'b1)
    aut(EVT_ADDR);
    `CHK(o_event_flag, 1'b0)
    aut(EVT_START);
    `CHK(o_slave_inhibit, 1'b0)
    $display("slave write test done");
    for (int i = 0; i < 5; i++) begin
      ev(codes[i], 1'b1, 1'b0, 8'h00);
      `CHK({o_status_vec, o_ack_request_flag, o_arbitration_lost_flag}, exps[i])
      commit(stas[i], 1'b0, 1'b0);
      `CHK(o_lk_start_req, stas[i])
    end
    $display("arbitration test done");
    close_out();
  end

  initial begin
    #200us;
    err_count++;
    close_out();
  end
endmodule
